// *** src/drive_io_pkg.sv ***
// Package of the drive I/O block: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package drive_io_pkg;
   // Register byte offsets
   localparam logic [7:0] off_ctrl    = 8'h00;
   localparam logic [7:0] off_in_pol  = 8'h04;
   localparam logic [7:0] off_in_func = 8'h08;
   localparam logic [7:0] off_out_sel = 8'h0C;
   localparam logic [7:0] off_status  = 8'h10;
   localparam logic [7:0] off_irq_st  = 8'h14;
   localparam logic [7:0] off_irq_msk = 8'h18;
   localparam logic [7:0] off_cur_sw  = 8'h1C;
   localparam logic [7:0] off_cur_set = 8'h20;
   localparam logic [7:0] off_enc_cfg = 8'h24;
   localparam logic [7:0] off_enc_pos = 8'h28;
   localparam logic [7:0] off_cmd_pos = 8'h2C;

   localparam int n_inputs  = 6;
   localparam int n_outputs = 3;
   localparam int func_w    = 4;

   // Input functions
   localparam logic [3:0] fn_none  = 4'h0;
   localparam logic [3:0] fn_step  = 4'h1;
   localparam logic [3:0] fn_dir   = 4'h2;
   localparam logic [3:0] fn_enab  = 4'h3;
   localparam logic [3:0] fn_limit = 4'h4;
   localparam logic [3:0] fn_ref   = 4'h5;
   // Delivered: in6 step, in5 dir, in4 enable (4 bits per input)
   localparam logic [23:0] in_func_rst = 24'h123000;

   // Output sources
   localparam logic [1:0] osel_status = 2'h0;
   localparam logic [1:0] osel_low    = 2'h1;
   localparam logic [1:0] osel_high   = 2'h2;
   localparam logic [1:0] osel_input  = 2'h3;

   // Status codes on outputs 2,1
   localparam logic [1:0] code_error = 2'h0;
   localparam logic [1:0] code_idle  = 2'h1;
   localparam logic [1:0] code_busy  = 2'h2;
   localparam logic [1:0] code_ref   = 2'h3;

   // Ctrl fields
   localparam int ctrl_clkdir  = 0;
   localparam int ctrl_mon_en  = 1;
   localparam int ctrl_busy    = 2;
   localparam int ctrl_refok   = 3;
   localparam int ctrl_ovtemp  = 4;
   localparam logic [4:0] ctrl_rst = 5'h03;

   // Irq bits
   localparam int irq_err    = 0;
   localparam int irq_limit  = 1;
   localparam int irq_ovtemp = 2;
   localparam int irq_badres = 3;

   // Current in milliamps: 10 % of 4 A per switch step
   localparam int ref_current_ma = 4000;
   localparam int step_pct       = 10;
   localparam logic [12:0] ma_per_step = 13'(ref_current_ma * step_pct / 100);

   localparam logic [11:0] enc_ppr_rst = 12'd500;
   // Monitoring window: 500 ppr x4 = 2000 counts, 200 steps -> 10/step;
   // a tenth of a step is one count, so tolerance is one count.
   localparam logic [15:0] mon_tol_rst = 16'h0001;
endpackage : drive_io_pkg

// *** src/sync_2ff.sv ***
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is asynchronous to hclk.
module sync_2ff #(
   parameter int width = 1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [width-1:0] d,
   output logic      [width-1:0] q
);
   logic [width-1:0] meta_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : sync_2ff

// *** src/quad_decoder.sv ***
// Single-ended quadrature decoder with index capture, 4x counting.
// Assumes a, b, idx are already synchronised to hclk.
module quad_decoder #(
   parameter int cnt_w = 16
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             a,
   input  wire logic             b,
   input  wire logic             idx,
   input  wire logic             clear,
   output logic      [cnt_w-1:0] count_ff,
   output logic                  index_seen_ff
);
   logic a_ff;
   logic b_ff;
   logic idx_ff;
   logic step;
   logic up;

   // Gray transitions: exactly one of a, b changed
   assign step = (a ^ a_ff) ^ (b ^ b_ff);
   assign up   = a ^ b_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_ff   <= 1'b0;
         b_ff   <= 1'b0;
         idx_ff <= 1'b0;
      end else begin
         a_ff   <= a;
         b_ff   <= b;
         idx_ff <= idx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_ff <= '0;
      end else if (clear) begin
         count_ff <= '0;
      end else if (step) begin
         count_ff <= up ? count_ff + 1'b1 : count_ff - 1'b1;
      end
   end

   // Set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         index_seen_ff <= 1'b0;
      end else if (idx && !idx_ff) begin
         index_seen_ff <= 1'b1;
      end else if (clear) begin
         index_seen_ff <= 1'b0;
      end
   end
endmodule : quad_decoder

// *** src/drive_io_status_current_select.sv ***
// Digital I/O, status code, encoder monitor and current setpoint logic.
// Assumes an AHB-Lite master on hclk and asynchronous pins.
module drive_io_status_current_select #(
   parameter int enc_w = 16
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [5:0]  in_pins,
   input  wire logic [3:0]  cur_switch,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        enc_idx,
   output logic      [2:0]  out_pins,
   output logic      [12:0] cur_setpoint_ma,
   output logic             step_pulse,
   output logic             step_dir,
   output logic             drive_enable,
   output logic             irq
);
   localparam int ni = drive_io_pkg::n_inputs;

   function automatic logic res_ok(input logic [11:0] ppr);
      case (ppr)
         12'd192, 12'd200, 12'd256, 12'd400, 12'd500,
         12'd512, 12'd1000, 12'd1024, 12'd2000, 12'd2048: res_ok = 1'b1;
         default: res_ok = 1'b0;
      endcase
   endfunction : res_ok

   // Registers
   logic [4:0]        ctrl_ff;
   logic [ni-1:0]     in_pol_ff;
   logic [23:0]       in_func_ff;
   logic [5:0]        out_sel_ff;
   logic [3:0]        irq_st_ff;
   logic [3:0]        irq_msk_ff;
   logic [12:0]       cur_set_ff;
   logic [11:0]       enc_ppr_ff;
   logic [15:0]       mon_tol_ff;
   logic [enc_w-1:0]  cmd_pos_ff;

   // AHB address phase capture
   logic              wr_ff;
   logic              rd_ff;
   logic [7:0]        addr_ff;
   logic              take;
   assign take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff   <= 1'b0;
         rd_ff   <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_ff   <= take && hwrite;
         rd_ff   <= take && !hwrite;
         addr_ff <= take ? haddr[7:0] : addr_ff;
      end
   end

   // Synchronised pins
   logic [ni-1:0] in_s;
   logic [3:0]    sw_s;
   logic [2:0]    enc_s;

   sync_2ff #(.width(ni)) u_sync_in (
      .hclk(hclk), .hresetn(hresetn), .d(in_pins), .q(in_s));
   sync_2ff #(.width(4)) u_sync_sw (
      .hclk(hclk), .hresetn(hresetn), .d(cur_switch), .q(sw_s));
   sync_2ff #(.width(3)) u_sync_enc (
      .hclk(hclk), .hresetn(hresetn),
      .d({enc_idx, enc_b, enc_a}), .q(enc_s));

   logic [ni-1:0] in_act;
   assign in_act = in_s ^ in_pol_ff;

   // Function routing; step source pinned to input 6 in clk-dir
   logic f_step;
   logic f_dir;
   logic f_enab;
   logic f_limit;
   logic f_ref;
   always_comb begin
      f_step  = 1'b0;
      f_dir   = 1'b0;
      f_enab  = 1'b0;
      f_limit = 1'b0;
      f_ref   = 1'b0;
      for (int i = 0; i < ni; i++) begin
         case (in_func_ff[i*4 +: 4])
            drive_io_pkg::fn_step:  f_step  = f_step  | in_act[i];
            drive_io_pkg::fn_dir:   f_dir   = f_dir   | in_act[i];
            drive_io_pkg::fn_enab:  f_enab  = f_enab  | in_act[i];
            drive_io_pkg::fn_limit: f_limit = f_limit | in_act[i];
            drive_io_pkg::fn_ref:   f_ref   = f_ref   | in_act[i];
            default: ;
         endcase
      end
      if (ctrl_ff[drive_io_pkg::ctrl_clkdir]) begin
         f_step = in_act[ni-1];
      end
   end

   // Encoder
   logic [enc_w-1:0] enc_cnt;
   logic             idx_seen;
   logic             enc_clr;
   assign enc_clr = wr_ff && addr_ff == drive_io_pkg::off_enc_pos;

   quad_decoder #(.cnt_w(enc_w)) u_quad (
      .hclk(hclk), .hresetn(hresetn),
      .a(enc_s[0]), .b(enc_s[1]), .idx(enc_s[2]),
      .clear(enc_clr), .count_ff(enc_cnt), .index_seen_ff(idx_seen));

   // Commanded position from step edges, scaled to encoder counts
   logic step_d_ff;
   logic step_edge;
   logic [enc_w-1:0] counts_per_step;
   assign step_edge = f_step && !step_d_ff && f_enab;
   // 200 full steps/rev, 4x decode: ppr/50 counts per step
   assign counts_per_step = enc_w'(enc_ppr_ff / 12'd50);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_d_ff  <= 1'b0;
         cmd_pos_ff <= '0;
      end else begin
         step_d_ff <= f_step;
         if (enc_clr) begin
            cmd_pos_ff <= '0;
         end else if (step_edge) begin
            cmd_pos_ff <= f_dir ? cmd_pos_ff - counts_per_step
                                : cmd_pos_ff + counts_per_step;
         end
      end
   end

   logic [enc_w-1:0] pos_err;
   logic [enc_w-1:0] pos_abs;
   logic             stall;
   assign pos_err = cmd_pos_ff - enc_cnt;
   assign pos_abs = pos_err[enc_w-1] ? enc_w'(-pos_err) : pos_err;
   assign stall   = ctrl_ff[drive_io_pkg::ctrl_mon_en]
                    && res_ok(enc_ppr_ff)
                    && (pos_abs > enc_w'(mon_tol_ff) + counts_per_step);

   // Error and limit outrank ref, busy, idle
   logic [1:0] code;
   always_comb begin
      if (stall || f_limit) begin
         code = drive_io_pkg::code_error;
      end else if (ctrl_ff[drive_io_pkg::ctrl_refok] || f_ref) begin
         code = drive_io_pkg::code_ref;
      end else if (ctrl_ff[drive_io_pkg::ctrl_busy]) begin
         code = drive_io_pkg::code_busy;
      end else begin
         code = drive_io_pkg::code_idle;
      end
   end

   logic [2:0] stat_bits;
   assign stat_bits = {ctrl_ff[drive_io_pkg::ctrl_ovtemp], code};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_pins <= 3'h0;
      end else begin
         for (int k = 0; k < drive_io_pkg::n_outputs; k++) begin
            case (out_sel_ff[k*2 +: 2])
               drive_io_pkg::osel_status: out_pins[k] <= stat_bits[k];
               drive_io_pkg::osel_low:    out_pins[k] <= 1'b0;
               drive_io_pkg::osel_high:   out_pins[k] <= 1'b1;
               default:                   out_pins[k] <= in_act[k];
            endcase
         end
      end
   end

   // Setpoint: switch 1 LSB, zero picks software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_setpoint_ma <= 13'h0000;
      end else if (sw_s == 4'h0) begin
         cur_setpoint_ma <= cur_set_ff;
      end else begin
         cur_setpoint_ma <= 13'(sw_s * drive_io_pkg::ma_per_step);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_pulse   <= 1'b0;
         step_dir     <= 1'b0;
         drive_enable <= 1'b0;
      end else begin
         step_pulse   <= step_edge;
         step_dir     <= f_dir;
         drive_enable <= f_enab;
      end
   end

   // Register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff    <= drive_io_pkg::ctrl_rst;
         in_pol_ff  <= '0;
         in_func_ff <= drive_io_pkg::in_func_rst;
         out_sel_ff <= 6'h00;
         irq_msk_ff <= 4'h0;
         cur_set_ff <= 13'h0000;
         enc_ppr_ff <= drive_io_pkg::enc_ppr_rst;
         mon_tol_ff <= drive_io_pkg::mon_tol_rst;
      end else if (wr_ff) begin
         case (addr_ff)
            drive_io_pkg::off_ctrl:    ctrl_ff    <= hwdata[4:0];
            drive_io_pkg::off_in_pol:  in_pol_ff  <= hwdata[ni-1:0];
            drive_io_pkg::off_in_func: in_func_ff <= hwdata[23:0];
            drive_io_pkg::off_out_sel: out_sel_ff <= hwdata[5:0];
            drive_io_pkg::off_irq_msk: irq_msk_ff <= hwdata[3:0];
            drive_io_pkg::off_cur_set: cur_set_ff <= hwdata[12:0];
            drive_io_pkg::off_enc_cfg: begin
               if (res_ok(hwdata[11:0])) begin
                  enc_ppr_ff <= hwdata[11:0];
               end
               mon_tol_ff <= hwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // Sticky events; set wins over read-clear
   logic       limit_d_ff;
   logic       stall_d_ff;
   logic       ovt_d_ff;
   logic [3:0] ev;
   logic       bad_wr;
   assign bad_wr = wr_ff && addr_ff == drive_io_pkg::off_enc_cfg
                   && !res_ok(hwdata[11:0]);
   always_comb begin
      ev = 4'h0;
      ev[drive_io_pkg::irq_err]    = stall && !stall_d_ff;
      ev[drive_io_pkg::irq_limit]  = f_limit && !limit_d_ff;
      ev[drive_io_pkg::irq_ovtemp] = ctrl_ff[drive_io_pkg::ctrl_ovtemp]
                                     && !ovt_d_ff;
      ev[drive_io_pkg::irq_badres] = bad_wr;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         limit_d_ff <= 1'b0;
         stall_d_ff <= 1'b0;
         ovt_d_ff   <= 1'b0;
         irq_st_ff  <= 4'h0;
         irq        <= 1'b0;
      end else begin
         limit_d_ff <= f_limit;
         stall_d_ff <= stall;
         ovt_d_ff   <= ctrl_ff[drive_io_pkg::ctrl_ovtemp];
         if (rd_ff && addr_ff == drive_io_pkg::off_irq_st) begin
            irq_st_ff <= ev;
         end else begin
            irq_st_ff <= irq_st_ff | ev;
         end
         irq <= |((irq_st_ff | ev) & irq_msk_ff);
      end
   end

   // Read data, registered: answer in the data phase after one wait
   logic [31:0] rmux;
   always_comb begin
      case (addr_ff)
         drive_io_pkg::off_ctrl:    rmux = {27'h0, ctrl_ff};
         drive_io_pkg::off_in_pol:  rmux = {26'h0, in_pol_ff};
         drive_io_pkg::off_in_func: rmux = {8'h00, in_func_ff};
         drive_io_pkg::off_out_sel: rmux = {26'h0, out_sel_ff};
         drive_io_pkg::off_status:  rmux = {15'h0, idx_seen, stall,
                                           out_pins, in_act, in_s};
         drive_io_pkg::off_irq_st:  rmux = {28'h0, irq_st_ff};
         drive_io_pkg::off_irq_msk: rmux = {28'h0, irq_msk_ff};
         drive_io_pkg::off_cur_sw:  rmux = {15'h0, cur_setpoint_ma, sw_s};
         drive_io_pkg::off_cur_set: rmux = {19'h0, cur_set_ff};
         drive_io_pkg::off_enc_cfg: rmux = {mon_tol_ff, 4'h0, enc_ppr_ff};
         drive_io_pkg::off_enc_pos: rmux = 32'(enc_cnt);
         drive_io_pkg::off_cmd_pos: rmux = 32'(cmd_pos_ff);
         default:                   rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hrdata    <= rd_ff ? rmux : hrdata;
         hreadyout <= !(take && !hwrite);
         hresp     <= 1'b0;
      end
   end
endmodule : drive_io_status_current_select

// *** bench/drive_io_props.sv ***
// Port checker of the drive I/O block.
// Assumes one hclk domain and a single AHB-Lite slave on the bus.
module drive_io_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [3:0]  cur_switch,
   input wire logic [12:0] cur_setpoint_ma,
   input wire logic        step_pulse
);
   logic take;
   logic rd_take;
   assign take    = hsel & hready & htrans[1];
   assign rd_take = take & ~hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_always_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_idle_ready: assert property (!rd_take |=> hreadyout)
      else $error("needless wait state");
   a_rdata_stands: assert property ($changed(hrdata) |->
      $past(rd_take) || $past(rd_take, 2))
      else $error("read data moved without a read");
   a_switch_setpoint: assert property (($stable(cur_switch) &&
      cur_switch != 4'h0) [*6] |->
      cur_setpoint_ma == 13'(cur_switch) * 13'h190)
      else $error("setpoint not switch times 400 mA");
   a_soft_setpoint: assert property (
      (cur_switch == 4'h0 && !take) [*8] |-> $stable(cur_setpoint_ma))
      else $error("software setpoint moved without a write");
   a_step_single: assert property (step_pulse |=> !step_pulse)
      else $error("step pulse longer than one cycle");
endmodule : drive_io_props

bind drive_io_status_current_select drive_io_props u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .cur_switch(cur_switch),
   .cur_setpoint_ma(cur_setpoint_ma), .step_pulse(step_pulse));

// *** bench/drive_far_side.sv ***
// Far side: indexer on the step input, encoder on the shaft.
// Assumes callers enter tasks just after a rising hclk edge.
module drive_far_side (
   input  wire logic       hclk,
   input  wire logic [4:0] static_pins,
   output logic      [5:0] in_pins,
   output logic            enc_a,
   output logic            enc_b,
   output logic            enc_idx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       step_ff;
   logic [1:0] seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
   assign in_pins = {step_ff, static_pins};
   initial begin
      step_ff = 1'b0;
      enc_a   = 1'b0;
      enc_b   = 1'b0;
      enc_idx = 1'b0;
   end
   task automatic send_steps(input int n);
      repeat (n) begin
         step_ff <= 1'b1;
         repeat (4) @(posedge hclk);
         step_ff <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask : send_steps
   task automatic enc_turn(input int n);
      for (int i = 0; i < n; i++) begin
         for (int j = 0; j < 4; j++) begin
            {enc_a, enc_b} <= seq[j];
            enc_idx        <= (i == 0 && j == 0);
            repeat (4) @(posedge hclk);
         end
      end
      enc_idx <= 1'b0;
   endtask : enc_turn
endmodule : drive_far_side

// *** bench/drive_io_status_current_select_tb_top.sv ***
// Self-checking bench of the drive I/O block.
// Assumes the far-side model drives the pins and the encoder.
module drive_io_status_current_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [5:0]  in_pins;
   logic [4:0]  static_pins;
   logic [3:0]  cur_switch;
   logic        enc_a;
   logic        enc_b;
   logic        enc_idx;
   logic [2:0]  out_pins;
   logic [12:0] cur_setpoint_ma;
   logic        step_pulse;
   logic        step_dir;
   logic        drive_enable;
   logic        irq;
   logic [31:0] rd;
   logic [31:0] v;
   logic        irq_a;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n_steps = 0;
   int          n0;
   int          ppr_list [$] = '{192, 200, 256, 400, 500, 512, 1000,
                                 1024, 2000, 2048};
   logic [4:0]  cv [4] = '{5'h01, 5'h05, 5'h09, 5'h0D};
   logic [1:0]  cc [4] = '{2'h1, 2'h2, 2'h3, 2'h3};

   drive_io_status_current_select u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .in_pins(in_pins),
      .cur_switch(cur_switch), .enc_a(enc_a), .enc_b(enc_b),
      .enc_idx(enc_idx), .out_pins(out_pins),
      .cur_setpoint_ma(cur_setpoint_ma), .step_pulse(step_pulse),
      .step_dir(step_dir), .drive_enable(drive_enable), .irq(irq));
   drive_far_side u_far (.hclk(hclk), .static_pins(static_pins),
      .in_pins(in_pins), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));

   always #12.5 hclk = ~hclk;
   assign hready = hreadyout;
   always @(posedge hclk) begin
      if (step_pulse === 1'b1) n_steps++;
   end

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk_reg(input string s, input logic [31:0] e,
                          input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask : chk_reg
   task automatic chk_pin(input string s, input logic [12:0] e,
                          input logic [12:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask : chk_pin
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fail_count++;
            $display("unexpected hreadyout: expected 1, seen 0");
            stop_test();
         end
         @(posedge hclk);
      end
   endtask : wait_ready
   task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask : ahb_write
   task automatic ahb_read(input logic [7:0] a);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wait_ready();
      htrans <= 2'h0;
      wait_ready();
      rd = hrdata;
   endtask : ahb_read
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      ahb_read(a);
      chk_reg($sformatf("reg %h", a), e, rd);
   endtask : rd_chk
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      static_pins = 5'h00;
      cur_switch = 4'h0;
      void'($urandom(54));
      cyc(6);
      hresetn <= 1'b1;
      cyc(1);
      rd_chk(drive_io_pkg::off_ctrl, 32'h00000003);
      rd_chk(drive_io_pkg::off_in_func, 32'h00123000);
      rd_chk(drive_io_pkg::off_enc_cfg, 32'h000101F4);
      ahb_write(8'h40, 32'hFFFFFFFF);
      rd_chk(8'h40, 32'h00000000);
      // Switch setpoint, every nonzero value then software path
      for (int sw = 1; sw < 16; sw++) begin
         cur_switch <= 4'(sw);
         cyc(8);
         chk_pin("setpoint", 13'(sw * 4000 / 10), cur_setpoint_ma);
         rd_chk(drive_io_pkg::off_cur_sw, 32'(sw * 6400 + sw));
      end
      v = $urandom % 8192;
      ahb_write(drive_io_pkg::off_cur_set, v);
      cur_switch <= 4'h0;
      cyc(8);
      chk_pin("soft setpoint", v[12:0], cur_setpoint_ma);
      ahb_write(drive_io_pkg::off_ctrl, 32'h00000001);
      ahb_write(drive_io_pkg::off_irq_msk, 32'h0000000F);
      for (int i = 0; i < 4; i++) begin
         ahb_write(drive_io_pkg::off_ctrl, 32'(cv[i]));
         cyc(4);
         chk_pin("code", 13'(cc[i]), 13'(out_pins[1:0]));
      end
      ahb_write(drive_io_pkg::off_in_func, 32'h00123004);
      static_pins <= 5'h01;
      cyc(8);
      chk_pin("limit code", 13'h0, 13'(out_pins[1:0]));
      ahb_write(drive_io_pkg::off_ctrl, 32'h0000001D);
      cyc(4);
      chk_pin("overtemp", 13'h4, 13'(out_pins));
      irq_a = irq;
      rd_chk(drive_io_pkg::off_irq_st, 32'h00000006);
      cyc(4);
      chk_pin("irq cleared", 13'h0, 13'(irq));
      ahb_write(drive_io_pkg::off_irq_msk, 32'h00000000);
      static_pins <= 5'h00;
      ahb_write(drive_io_pkg::off_ctrl, 32'h00000001);
      cyc(6);
      static_pins <= 5'h01;
      ahb_write(drive_io_pkg::off_ctrl, 32'h0000001D);
      cyc(6);
      chk_pin("irq mask", 13'h1, 13'(irq_a ^ irq));
      rd_chk(drive_io_pkg::off_irq_st, 32'h00000006);
      static_pins <= 5'h00;
      ahb_write(drive_io_pkg::off_ctrl, 32'h00000001);
      ahb_write(drive_io_pkg::off_in_func, 32'h00123000);
      ahb_write(drive_io_pkg::off_out_sel, 32'h00000026);
      cyc(4);
      chk_pin("out select", 13'h5, 13'(out_pins));
      ahb_write(drive_io_pkg::off_out_sel, 32'h0000003F);
      repeat (3) begin
         v = $urandom;
         ahb_write(drive_io_pkg::off_in_pol, {26'h0, v[5:0]});
         static_pins <= v[12:8];
         cyc(6);
         chk_pin("out input", 13'(v[10:8] ^ v[2:0]), 13'(out_pins));
         ahb_read(drive_io_pkg::off_status);
         chk_reg("status", {20'h0, {1'b0, v[12:8]} ^ v[5:0],
                 {1'b0, v[12:8]}}, rd & 32'h00000FFF);
      end
      ahb_write(drive_io_pkg::off_out_sel, 32'h00000000);
      ahb_write(drive_io_pkg::off_in_pol, 32'h00000000);
      static_pins <= 5'h18;
      cyc(6);
      n0 = n_steps;
      u_far.send_steps(5);
      cyc(6);
      chk_pin("steps", 13'h5, 13'(n_steps - n0));
      chk_pin("dir", 13'h1, 13'(step_dir));
      static_pins <= 5'h10;
      cyc(6);
      u_far.send_steps(3);
      cyc(6);
      chk_pin("gated steps", 13'h5, 13'(n_steps - n0));
      ahb_write(drive_io_pkg::off_in_func, 32'h00120003);
      static_pins <= 5'h01;
      cyc(6);
      chk_pin("moved enable", 13'h1, 13'(drive_enable));
      ahb_write(drive_io_pkg::off_in_func, 32'h00123000);
      ahb_write(drive_io_pkg::off_enc_cfg, 32'h0001012C);
      rd_chk(drive_io_pkg::off_enc_cfg, 32'h000101F4);
      rd_chk(drive_io_pkg::off_irq_st, 32'h00000008);
      foreach (ppr_list[i]) begin
         v = {16'($urandom), 4'h0, 12'(ppr_list[i])};
         ahb_write(drive_io_pkg::off_enc_cfg, v);
         rd_chk(drive_io_pkg::off_enc_cfg, v);
      end
      ahb_write(drive_io_pkg::off_enc_cfg, 32'h000101F4);
      ahb_write(drive_io_pkg::off_enc_pos, 32'h00000000);
      u_far.enc_turn(3);
      cyc(6);
      rd_chk(drive_io_pkg::off_enc_pos, 32'h0000000C);
      ahb_read(drive_io_pkg::off_status);
      chk_reg("index seen", 32'h1, {31'h0, rd[16]});
      chk_reg("monitor off", 32'h0, {31'h0, rd[15]});
      ahb_write(drive_io_pkg::off_ctrl, 32'h00000003);
      cyc(4);
      chk_pin("stall code", 13'h0, 13'(out_pins[1:0]));
      ahb_read(drive_io_pkg::off_status);
      chk_reg("stall", 32'h1, {31'h0, rd[15]});
      stop_test();
   end
endmodule : drive_io_status_current_select_tb_top
